// >>> src/tdl_pkg.sv
// Shared constants for the T1 data link code and byte access block
package tdl_pkg;
   // Register offsets as printed
   localparam logic [8:0] ADR_RX_CODE_CTRL = 9'h015;
   localparam logic [8:0] ADR_RX_DL_BYTE = 9'h062;
   localparam logic [8:0] ADR_RX_CODE_VAL = 9'h063;
   localparam logic [8:0] ADR_RX_LSTAT7 = 9'h096;
   localparam logic [8:0] ADR_RX_IMASK7 = 9'h0a6;
   localparam logic [8:0] ADR_TX_LCTRL2 = 9'h113;
   localparam logic [8:0] ADR_TX_DL_BYTE = 9'h162;
   localparam logic [8:0] ADR_TX_CODE_VAL = 9'h163;
   localparam logic [8:0] ADR_TX_CTRL1 = 9'h181;
   localparam logic [8:0] ADR_TX_CTRL2 = 9'h182;
   localparam logic [8:0] ADR_TX_LSTAT2 = 9'h191;
   localparam logic [8:0] ADR_TX_IMASK2 = 9'h1a1;
   // Reset value of every register
   localparam logic [7:0] REG_RST = 8'h00;
   // Field positions
   localparam int BIT_SEND_CODE = 6;
   localparam int BIT_PASS_THRU = 6;
   localparam int BIT_DL_SOURCE = 7;
   localparam int BIT_CODE_DET = 0;
   localparam int BIT_CODE_CLR = 1;
   localparam int BIT_RX_FULL = 2;
   localparam int BIT_TX_EMPTY = 4;
   localparam int FLD_FILT_LO = 0;
   localparam int FLD_DISINT_LO = 4;
   // Code word framing: eight ones, zero, six code bits, zero
   localparam logic [7:0] CODE_FLAG = 8'hff;
   localparam logic [3:0] CODE_LAST_IDX = 4'hf;
   localparam logic [4:0] CODE_FRAME_BITS = 5'h10;
   // Byte serializer lengths
   localparam logic [3:0] DL_LAST_ESF = 4'h7;
   localparam logic [3:0] DL_LAST_D4 = 4'h5;
   localparam logic [7:0] D4_BYTE_MASK = 8'h3f;
   // Transmit code controller states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_SEND = 3'b010,
      TX_ABORT = 3'b100
   } tdl_tx_state_e;
endpackage

// >>> src/tdl_boc_fdl.sv
// T1 data link: code generator and detector, byte-wide link serializer and collector
//
// Functional notes
// [R1] Code logic works only in T1 mode
// [R2] Generator sends low six bits of code register
// [R3] Send-code bit starts insertion at once, continuous
// [R4] Abort sequence follows automatically when sending stops
// [R5] Insertion only while framing pass-through is zero
// [R6] Host writes code before setting send bit
// [R7] Extended superframe: received link bits searched continuously
// [R8] Detected flag after code persists filter count
// [R9] Detected code readable in receive code register
// [R10] Detected flag stays clear until new detection
// [R11] Cleared flag after code absent disintegration count
// [R12] Masked code flags drive interrupt output low
// [R13] Source bit selects byte serializer for link bits
// [R14] Transmit byte sent LSB first, no stuffing
// [R15] Empty flag after byte shifted, masked interrupt
// [R16] Unrefreshed transmit byte is sent again
// [R17] D4 pattern needs 1Ch and source zero
// [R18] D4 transmit uses only lower six bits
// [R19] Received bits shifted LSB first into byte
// [R20] Full flag on fill, masked interrupt
// [R21] Received byte is raw, no destuffing
// [R22] D4 receive byte updates on multiframe boundary
// [R23] Two-bit selects pick one of four thresholds
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tdl_boc_fdl
   import tdl_pkg::*;
#(
   parameter logic [15:0] FILT_TBL = 16'h7531,
   parameter logic [15:0] DISINT_TBL = 16'h7531,
   parameter logic [4:0] ABORT_BITS = 5'h10
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [8:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   input wire logic t1_mode,
   input wire logic esf_mode,
   input wire logic tx_bit_req,
   input wire logic tx_serial_in,
   output logic tx_dl_bit,
   output logic tx_dl_insert,
   input wire logic rx_bit_stb,
   input wire logic rx_bit,
   input wire logic rx_mf_stb,
   output logic interrupt_out_n
);

   // Threshold lookup from a table of four nibbles
   function automatic logic [3:0] sel_thresh(input logic [1:0] sel, input logic [15:0] tbl);
      logic [3:0] t;
      t = tbl[{sel, 2'b00} +: 4];
      if (t == 4'h0) begin
         t = 4'h1;
      end
      return t;
   endfunction

   // Software registers
   logic [7:0] rx_code_control_r, rx_data_link_byte_r, rx_code_value_r;
   logic [7:0] rx_latched_status_seven_r, rx_interrupt_mask_seven_r;
   logic [7:0] tx_link_control_two_r, tx_data_link_byte_r, tx_code_value_r;
   logic [7:0] tx_control_one_r, tx_control_two_r;
   logic [7:0] tx_latched_status_two_r, tx_interrupt_mask_two_r;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic interrupt_out_n_r;

   // Transmit side state
   tdl_tx_state_e tx_state_r, tx_state_nxt;
   logic [3:0] code_idx_r;
   logic [5:0] code_lat_r;
   logic [4:0] abort_cnt_r;
   logic [7:0] tx_sh_r;
   logic [3:0] tx_cnt_r;
   logic tx_dl_bit_r, tx_dl_insert_r;
   logic fbit_meta_r, fbit_sync_r;

   // Receive side state
   logic [15:0] win_r;
   logic [4:0] gap_r;
   logic [5:0] cand_r;
   logic [3:0] hit_r, miss_r;
   logic detected_r;
   logic [7:0] rx_sh_r;
   logic [3:0] rx_cnt_r;

   // Write decode
   wire wr_rx_ctrl = wr_stb && (addr == ADR_RX_CODE_CTRL);
   wire wr_rx_stat = wr_stb && (addr == ADR_RX_LSTAT7);
   wire wr_rx_mask = wr_stb && (addr == ADR_RX_IMASK7);
   wire wr_tx_lc2 = wr_stb && (addr == ADR_TX_LCTRL2);
   wire wr_tx_byte = wr_stb && (addr == ADR_TX_DL_BYTE);
   wire wr_tx_code = wr_stb && (addr == ADR_TX_CODE_VAL);
   wire wr_tx_c1 = wr_stb && (addr == ADR_TX_CTRL1);
   wire wr_tx_c2 = wr_stb && (addr == ADR_TX_CTRL2);
   wire wr_tx_stat = wr_stb && (addr == ADR_TX_LSTAT2);
   wire wr_tx_mask = wr_stb && (addr == ADR_TX_IMASK2);

   // Mode qualifiers
   wire code_mode = t1_mode && esf_mode; // [R1] [R7]
   wire send_en = tx_link_control_two_r[BIT_SEND_CODE];
   wire pass_thru = tx_control_one_r[BIT_PASS_THRU];
   wire byte_src = t1_mode && !tx_control_two_r[BIT_DL_SOURCE]; // [R13] [R17]

   // Code word being sent, low six bits of the code register
   wire [15:0] code_pat = {1'b0, code_lat_r, 1'b0, CODE_FLAG}; // [R2]
   wire tx_busy = (tx_state_r != TX_IDLE);
   wire code_bit = (tx_state_r == TX_SEND) ? code_pat[code_idx_r] : 1'b1; // [R4]

   // Byte serializer selection, D4 keeps six bits
   wire [3:0] tx_last = esf_mode ? DL_LAST_ESF : DL_LAST_D4;
   wire [7:0] tx_load = esf_mode ? tx_data_link_byte_r : (tx_data_link_byte_r & D4_BYTE_MASK); // [R18]
   wire [7:0] tx_cur = (tx_cnt_r == 4'h0) ? tx_load : tx_sh_r; // [R16]
   wire tx_byte_done = tx_bit_req && byte_src && !tx_busy && (tx_cnt_r == tx_last);
   wire set_tx_empty = tx_byte_done; // [R15]

   // Outgoing bit choice; pass-through keeps the sampled framing bit
   wire ins_w = t1_mode && !pass_thru && (tx_busy || byte_src); // [R5]
   wire bit_w = !ins_w ? fbit_sync_r : (tx_busy ? code_bit : tx_cur[0]); // [R14]

   // Receive code search over the last sixteen bits
   wire [15:0] win_nxt = {rx_bit, win_r[15:1]};
   wire rx_code_stb = rx_bit_stb && code_mode;
   wire match_w = (win_nxt[7:0] == CODE_FLAG) && !win_nxt[8] && !win_nxt[15];
   wire [5:0] code_w = win_nxt[14:9];
   wire miss_w = rx_code_stb && !match_w && ((gap_r + 5'h01) == CODE_FRAME_BITS);
   wire [3:0] filt_th = sel_thresh(rx_code_control_r[FLD_FILT_LO +: 2], FILT_TBL); // [R23]
   wire [3:0] dis_th = sel_thresh(rx_code_control_r[FLD_DISINT_LO +: 2], DISINT_TBL); // [R23]
   wire same_code = (code_w == cand_r);
   wire [3:0] hit_nxt = same_code ? ((hit_r == 4'hf) ? hit_r : hit_r + 4'h1) : 4'h1;
   wire hit_ok = rx_code_stb && match_w && (hit_nxt >= filt_th);
   wire new_code = !detected_r || (code_w != rx_code_value_r[5:0]);
   wire set_det = hit_ok && new_code && (hit_nxt == filt_th || !detected_r); // [R8] [R10]
   wire [3:0] miss_nxt = (miss_r == 4'hf) ? miss_r : miss_r + 4'h1;
   wire set_clr = miss_w && detected_r && (miss_nxt >= dis_th); // [R11]

   // Receive byte collector
   wire [7:0] rx_sh_nxt = {rx_bit, rx_sh_r[7:1]}; // [R19] [R21]
   wire rx_esf_full = t1_mode && esf_mode && rx_bit_stb && (rx_cnt_r == DL_LAST_ESF);
   wire rx_d4_full = t1_mode && !esf_mode && rx_mf_stb; // [R22]
   wire set_rx_full = rx_esf_full || rx_d4_full; // [R20]

   // Latched flags: a new event wins over a clear in the same cycle
   wire [7:0] rx_set = {5'h00, set_rx_full, set_clr, set_det};
   wire [7:0] rx_w1c = wr_rx_stat ? wr_data : 8'h00;
   wire [7:0] rx_stat_nxt = (rx_latched_status_seven_r & ~rx_w1c) | rx_set;
   wire [7:0] tx_set = {3'h0, set_tx_empty, 4'h0};
   wire [7:0] tx_w1c = wr_tx_stat ? wr_data : 8'h00;
   wire [7:0] tx_stat_nxt = (tx_latched_status_two_r & ~tx_w1c) | tx_set;
   wire irq_w = |(rx_latched_status_seven_r & rx_interrupt_mask_seven_r & 8'h07) ||
                (tx_latched_status_two_r[BIT_TX_EMPTY] && tx_interrupt_mask_two_r[BIT_TX_EMPTY]);

   // Read decode, unmapped offsets read zero
   always_comb begin
      if (addr == ADR_RX_CODE_CTRL) begin
         rd_data_nxt = rx_code_control_r;
      end else if (addr == ADR_RX_DL_BYTE) begin
         rd_data_nxt = rx_data_link_byte_r;
      end else if (addr == ADR_RX_CODE_VAL) begin
         rd_data_nxt = rx_code_value_r; // [R9]
      end else if (addr == ADR_RX_LSTAT7) begin
         rd_data_nxt = rx_latched_status_seven_r;
      end else if (addr == ADR_RX_IMASK7) begin
         rd_data_nxt = rx_interrupt_mask_seven_r;
      end else if (addr == ADR_TX_LCTRL2) begin
         rd_data_nxt = tx_link_control_two_r;
      end else if (addr == ADR_TX_DL_BYTE) begin
         rd_data_nxt = tx_data_link_byte_r;
      end else if (addr == ADR_TX_CODE_VAL) begin
         rd_data_nxt = tx_code_value_r;
      end else if (addr == ADR_TX_CTRL1) begin
         rd_data_nxt = tx_control_one_r;
      end else if (addr == ADR_TX_CTRL2) begin
         rd_data_nxt = tx_control_two_r;
      end else if (addr == ADR_TX_LSTAT2) begin
         rd_data_nxt = tx_latched_status_two_r;
      end else if (addr == ADR_TX_IMASK2) begin
         rd_data_nxt = tx_interrupt_mask_two_r;
      end else begin
         rd_data_nxt = 8'h00;
      end
   end

   // Transmit code controller next state
   always_comb begin
      tx_state_nxt = tx_state_r;
      case (tx_state_r)
         TX_IDLE: begin
            if (send_en && code_mode) begin
               tx_state_nxt = TX_SEND; // [R3]
            end
         end
         TX_SEND: begin
            if (!send_en || !code_mode) begin
               tx_state_nxt = TX_ABORT; // [R4]
            end
         end
         TX_ABORT: begin
            if (send_en && code_mode) begin
               tx_state_nxt = TX_SEND;
            end else if (tx_bit_req && (abort_cnt_r == ABORT_BITS - 5'h01)) begin
               tx_state_nxt = TX_IDLE;
            end
         end
         default: tx_state_nxt = TX_IDLE;
      endcase
   end

   // Host-written registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_code_control_r <= REG_RST;
         rx_interrupt_mask_seven_r <= REG_RST;
         tx_link_control_two_r <= REG_RST;
         tx_data_link_byte_r <= REG_RST;
         tx_code_value_r <= REG_RST;
         tx_control_one_r <= REG_RST;
         tx_control_two_r <= REG_RST;
         tx_interrupt_mask_two_r <= REG_RST;
      end else begin
         if (wr_rx_ctrl) rx_code_control_r <= wr_data;
         if (wr_rx_mask) rx_interrupt_mask_seven_r <= wr_data;
         if (wr_tx_lc2) tx_link_control_two_r <= wr_data;
         if (wr_tx_byte) tx_data_link_byte_r <= wr_data;
         if (wr_tx_code) tx_code_value_r <= wr_data;
         if (wr_tx_c1) tx_control_one_r <= wr_data;
         if (wr_tx_c2) tx_control_two_r <= wr_data;
         if (wr_tx_mask) tx_interrupt_mask_two_r <= wr_data;
      end
   end

   // Status flags, read data and interrupt
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_latched_status_seven_r <= REG_RST;
         tx_latched_status_two_r <= REG_RST;
         rd_data_r <= REG_RST;
         interrupt_out_n_r <= 1'b1;
      end else begin
         rx_latched_status_seven_r <= rx_stat_nxt;
         tx_latched_status_two_r <= tx_stat_nxt;
         rd_data_r <= rd_stb ? rd_data_nxt : REG_RST;
         interrupt_out_n_r <= !irq_w; // [R12] [R15] [R20]
      end
   end

   // Framing bit from the serial input pin, two-stage synchroniser
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fbit_meta_r <= 1'b0;
         fbit_sync_r <= 1'b0;
      end else begin
         fbit_meta_r <= tx_serial_in;
         fbit_sync_r <= fbit_meta_r;
      end
   end

   // Transmit code word sequencing; code is latched at each word start
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_state_r <= TX_IDLE;
         code_idx_r <= 4'h0;
         code_lat_r <= 6'h00;
         abort_cnt_r <= 5'h00;
      end else begin
         tx_state_r <= tx_state_nxt;
         if (tx_state_r == TX_IDLE || (tx_state_r == TX_ABORT && tx_state_nxt == TX_SEND)) begin
            code_idx_r <= 4'h0;
            code_lat_r <= tx_code_value_r[5:0]; // [R2]
         end else if (tx_bit_req && tx_state_r == TX_SEND) begin
            code_idx_r <= code_idx_r + 4'h1;
            if (code_idx_r == CODE_LAST_IDX) code_lat_r <= tx_code_value_r[5:0];
         end
         if (tx_state_r != TX_ABORT) begin
            abort_cnt_r <= 5'h00;
         end else if (tx_bit_req) begin
            abort_cnt_r <= abort_cnt_r + 5'h01;
         end
      end
   end

   // Transmit byte serializer and outgoing bit
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tx_sh_r <= 8'h00;
         tx_cnt_r <= 4'h0;
         tx_dl_bit_r <= 1'b0;
         tx_dl_insert_r <= 1'b0;
      end else begin
         if (!byte_src) begin
            tx_cnt_r <= 4'h0;
         end else if (tx_bit_req && !tx_busy) begin
            tx_sh_r <= {1'b0, tx_cur[7:1]}; // [R14]
            tx_cnt_r <= tx_byte_done ? 4'h0 : tx_cnt_r + 4'h1;
         end
         if (tx_bit_req) begin
            tx_dl_bit_r <= bit_w;
            tx_dl_insert_r <= ins_w;
         end
      end
   end

   // Receive code detector
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         win_r <= 16'h0000;
         gap_r <= 5'h00;
         cand_r <= 6'h00;
         hit_r <= 4'h0;
         miss_r <= 4'h0;
         detected_r <= 1'b0;
         rx_code_value_r <= REG_RST;
      end else if (!code_mode) begin
         gap_r <= 5'h00;
         hit_r <= 4'h0;
         miss_r <= 4'h0;
         detected_r <= 1'b0;
      end else if (rx_code_stb) begin
         win_r <= win_nxt; // [R7]
         if (match_w) begin
            gap_r <= 5'h00;
            cand_r <= code_w;
            hit_r <= hit_nxt;
            miss_r <= 4'h0;
         end else if (miss_w) begin
            gap_r <= 5'h00;
            hit_r <= 4'h0;
            miss_r <= miss_nxt;
         end else begin
            gap_r <= gap_r + 5'h01;
         end
         if (set_det) begin
            detected_r <= 1'b1;
            rx_code_value_r <= {2'b00, code_w}; // [R9]
         end else if (set_clr) begin
            detected_r <= 1'b0; // [R10]
         end
      end
   end

   // Receive byte collector
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rx_sh_r <= 8'h00;
         rx_cnt_r <= 4'h0;
         rx_data_link_byte_r <= REG_RST;
      end else if (t1_mode) begin
         if (rx_bit_stb) begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= (rx_esf_full || !esf_mode) ? 4'h0 : rx_cnt_r + 4'h1;
         end
         if (rx_esf_full) begin
            rx_data_link_byte_r <= rx_sh_nxt; // [R19]
         end else if (rx_d4_full) begin
            rx_data_link_byte_r <= rx_sh_r; // [R22]
         end
      end
   end

   assign rd_data = rd_data_r;
   assign interrupt_out_n = interrupt_out_n_r;
   assign tx_dl_bit = tx_dl_bit_r;
   assign tx_dl_insert = tx_dl_insert_r;

endmodule
`default_nettype wire

// >>> verif/tdl_boc_fdl_props.sv
// Port-level checks for the data link block
`timescale 1ns/1ps
`default_nettype none
module tdl_boc_fdl_props
   import tdl_pkg::*;
#(
   parameter logic [4:0] ABORT_BITS = 5'h10
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [8:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic t1_mode,
   input wire logic esf_mode,
   input wire logic tx_bit_req,
   input wire logic tx_serial_in,
   input wire logic tx_dl_bit,
   input wire logic tx_dl_insert,
   input wire logic rx_bit_stb,
   input wire logic rx_bit,
   input wire logic rx_mf_stb,
   input wire logic interrupt_out_n
);
   logic pt_r, send_r, send_d_r, tmask_r;
   logic [2:0] rmask_r;
   logic [4:0] abort_r;
   // Slot decode and the end of a code send
   wire logic abort_go = send_d_r && !send_r;
   wire logic code_slot = tx_bit_req && t1_mode && esf_mode && !pt_r;
   // Shadows of control bits written over the register port
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pt_r <= 1'b0;
         send_r <= 1'b0;
         send_d_r <= 1'b0;
         tmask_r <= 1'b0;
         rmask_r <= 3'h0;
         abort_r <= 5'h00;
      end else begin
         send_d_r <= send_r;
         if (wr_stb && addr == ADR_TX_CTRL1) pt_r <= wr_data[BIT_PASS_THRU];
         if (wr_stb && addr == ADR_TX_LCTRL2) send_r <= wr_data[BIT_SEND_CODE];
         if (wr_stb && addr == ADR_TX_IMASK2) tmask_r <= wr_data[BIT_TX_EMPTY];
         if (wr_stb && addr == ADR_RX_IMASK7) rmask_r <= wr_data[2:0];
         if (abort_go) abort_r <= ABORT_BITS - 5'h01;
         else if (tx_bit_req && abort_r != 5'h00) abort_r <= abort_r - 5'h01;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_rd_idle;
      !rd_stb |=> rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
   property p_ctrl_rw;
      (wr_stb && addr == ADR_RX_CODE_CTRL) ##2 (rd_stb && addr == ADR_RX_CODE_CTRL)
         |=> rd_data == $past(wr_data, 3);
   endproperty
   a_ctrl_rw: assert property (p_ctrl_rw) else $error("code control readback");
   property p_e1_off;
      tx_bit_req && !t1_mode |=> !tx_dl_insert;
   endproperty
   a_e1_off: assert property (p_e1_off) else $error("insertion outside T1");
   property p_pass;
      tx_bit_req && pt_r |=> !tx_dl_insert;
   endproperty
   a_pass: assert property (p_pass) else $error("insertion during pass-through");
   property p_send;
      code_slot && send_r && send_d_r |=> tx_dl_insert;
   endproperty
   a_send: assert property (p_send) else $error("code slot not inserted");
   property p_abort;
      code_slot && !send_r && abort_r != 5'h00 |=> tx_dl_insert && tx_dl_bit;
   endproperty
   a_abort: assert property (p_abort) else $error("abort bit not a one");
   property p_hold;
      !tx_bit_req |=> $stable(tx_dl_bit) && $stable(tx_dl_insert);
   endproperty
   a_hold: assert property (p_hold) else $error("slot output moved");
   property p_irq_masked;
      rmask_r == 3'h0 && !tmask_r |=> interrupt_out_n;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt");
endmodule
`default_nettype wire

// >>> verif/tdl_line_model.sv
// Line-side model: framer bit slots to the block, received link bits into it
`timescale 1ns/1ps
`default_nettype none
module tdl_line_model #(
   parameter int SLOT_GAP = 20
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic tx_dl_bit,
   input wire logic tx_dl_insert,
   output logic tx_bit_req,
   output logic rx_bit_stb,
   output logic rx_bit,
   output logic rx_mf_stb
);
   int slot_cnt;
   logic req_d_r;
   logic [1:0] tx_q[$];
   initial begin
      tx_bit_req = 1'b0;
      rx_bit_stb = 1'b0;
      rx_bit = 1'b0;
      rx_mf_stb = 1'b0;
   end
   // One-cycle slot pulses; each answered slot is logged
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         slot_cnt <= 0;
         tx_bit_req <= 1'b0;
         req_d_r <= 1'b0;
      end else begin
         slot_cnt <= (slot_cnt == SLOT_GAP - 1) ? 0 : slot_cnt + 1;
         tx_bit_req <= (slot_cnt == 0);
         req_d_r <= tx_bit_req;
         if (req_d_r) tx_q.push_back({tx_dl_insert, tx_dl_bit});
      end
   end
   // Received bits, first bit first; the line toggles between slots
   task automatic send_bits(input logic [15:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         rx_bit_stb <= 1'b1;
         rx_bit <= w[i];
         @(posedge clk_sys);
         rx_bit_stb <= 1'b0;
         rx_bit <= ~w[i];
         @(posedge clk_sys);
      end
      repeat (2) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the T1 data link block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tdl_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [8:0] addr = 9'h000;
   logic [7:0] wr_data = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic t1_mode = 1'b1;
   logic esf_mode = 1'b1;
   logic tx_serial_in = 1'b0;
   wire logic tx_bit_req, rx_bit_stb, rx_bit, rx_mf_stb, tx_dl_bit, tx_dl_insert, interrupt_out_n;
   wire logic [7:0] rd_data;
   int fail_count = 0;
   int cmp_count = 0;
   int seed = 62116;
   int cyc = 0;
   logic [15:0] exp_q[$];
   logic [15:0] ent, w, got, ins_v;
   logic [7:0] last_rd, b, code;
   logic rd_seen = 1'b0;
   logic [8:0] regs [13] = '{ADR_RX_CODE_CTRL, ADR_RX_DL_BYTE, ADR_RX_CODE_VAL, ADR_RX_LSTAT7,
      ADR_RX_IMASK7, ADR_TX_LCTRL2, ADR_TX_DL_BYTE, ADR_TX_CODE_VAL, ADR_TX_CTRL1, ADR_TX_CTRL2,
      ADR_TX_LSTAT2, ADR_TX_IMASK2, 9'h000};
   always #50 clk_sys = ~clk_sys;
   tdl_boc_fdl tdl_boc_fdl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .t1_mode(t1_mode), .esf_mode(esf_mode), .tx_bit_req(tx_bit_req),
      .tx_serial_in(tx_serial_in), .tx_dl_bit(tx_dl_bit), .tx_dl_insert(tx_dl_insert),
      .rx_bit_stb(rx_bit_stb), .rx_bit(rx_bit), .rx_mf_stb(rx_mf_stb),
      .interrupt_out_n(interrupt_out_n));
   tdl_line_model tdl_line_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .tx_dl_bit(tx_dl_bit),
      .tx_dl_insert(tx_dl_insert), .tx_bit_req(tx_bit_req), .rx_bit_stb(rx_bit_stb),
      .rx_bit(rx_bit), .rx_mf_stb(rx_mf_stb));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Register port cycles; a strobe still pending costs one idle cycle
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      if (wr_stb || rd_stb) @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
      if (wr_stb || rd_stb) @(posedge clk_sys);
      exp_q.push_back({m, e & m});
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
   endtask
   task automatic wait_flag(input int bit_i);
      for (int i = 0; i < 200; i++) begin
         rd(ADR_TX_LSTAT2, 8'h00, 8'h00);
         @(negedge clk_sys);
         @(posedge clk_sys);
         if (last_rd[bit_i] === 1'b1) return;
      end
      check("flag wait", 8'h00, 8'h01);
   endtask
   // Gathers the next n answered slots
   task automatic collect(input int n);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      tdl_line_model_inst.tx_q.delete();
      while (tdl_line_model_inst.tx_q.size() < n) @(posedge clk_sys);
      got = 16'h0000;
      ins_v = 16'h0000;
      for (int i = 0; i < n; i++) begin
         got[i] = tdl_line_model_inst.tx_q[i][0];
         ins_v[i] = tdl_line_model_inst.tx_q[i][1];
      end
   endtask
   // Compares every read answer with the oldest noted expectation
   always @(negedge clk_sys) begin
      if (rd_seen && exp_q.size() > 0) begin
         ent = exp_q.pop_front();
         last_rd = rd_data;
         check("rd_data", rd_data & ent[15:8], ent[7:0]);
      end
      rd_seen = rd_stb;
   end
   // Random framing pin and the hang limit
   always @(posedge clk_sys) begin
      tx_serial_in <= 1'($random(seed));
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      foreach (regs[i]) rd(regs[i], REG_RST, 8'hff);
      b = 8'($random(seed));
      wr(ADR_RX_CODE_CTRL, b);
      rd(ADR_RX_CODE_CTRL, b, 8'hff);
      wr(ADR_RX_CODE_VAL, b);
      rd(ADR_RX_CODE_VAL, 8'h00, 8'hff);
      // Eight received bits fill the byte, first bit in bit 0
      wr(ADR_RX_IMASK7, 8'h04);
      tdl_line_model_inst.send_bits({8'h00, b}, 8);
      rd(ADR_RX_LSTAT7, 8'h04, 8'h04);
      rd(ADR_RX_DL_BYTE, b, 8'hff);
      check("irq", {7'h00, interrupt_out_n}, 8'h00);
      wr(ADR_RX_LSTAT7, 8'h04);
      rd(ADR_RX_LSTAT7, 8'h00, 8'h04);
      // Code needs three words at filter select 1, one empty slot clears it
      code = {2'b00, 6'($random(seed))};
      w = {1'b0, code[5:0], 1'b0, 8'hff};
      wr(ADR_RX_CODE_CTRL, 8'h01);
      wr(ADR_RX_IMASK7, 8'h03);
      repeat (2) tdl_line_model_inst.send_bits(w, 16);
      rd(ADR_RX_LSTAT7, 8'h00, 8'h01);
      tdl_line_model_inst.send_bits(w, 16);
      rd(ADR_RX_LSTAT7, 8'h01, 8'h01);
      rd(ADR_RX_CODE_VAL, code, 8'h3f);
      check("irq", {7'h00, interrupt_out_n}, 8'h00);
      wr(ADR_RX_LSTAT7, 8'h07);
      tdl_line_model_inst.send_bits(w, 16);
      rd(ADR_RX_LSTAT7, 8'h00, 8'h03);
      repeat (2) tdl_line_model_inst.send_bits(16'h0000, 16);
      rd(ADR_RX_LSTAT7, 8'h02, 8'h03);
      repeat (3) tdl_line_model_inst.send_bits(w, 16);
      rd(ADR_RX_LSTAT7, 8'h03, 8'h03);
      // Code send: value first, then send bit; abort ones after it stops
      wr(ADR_RX_IMASK7, 8'h00);
      wr(ADR_TX_CODE_VAL, {2'b11, code[5:0]});
      wr(ADR_TX_LCTRL2, 8'h40);
      collect(16);
      check("code lo", got[7:0], w[7:0]);
      check("code hi", got[15:8], w[15:8]);
      check("code ins", ins_v[7:0] & ins_v[15:8], 8'hff);
      wr(ADR_TX_LCTRL2, 8'h00);
      collect(15);
      check("abort", got[7:0] & got[14:8], 8'h7f);
      // Byte path: LSB first after the empty flag, resent if not refreshed
      wr(ADR_TX_IMASK2, 8'h10);
      b = 8'($random(seed));
      wr(ADR_TX_DL_BYTE, b);
      wr(ADR_TX_LSTAT2, 8'h10);
      wait_flag(BIT_TX_EMPTY);
      check("irq", {7'h00, interrupt_out_n}, 8'h00);
      wr(ADR_TX_LSTAT2, 8'h10);
      collect(8);
      check("byte", got[7:0], b);
      check("byte ins", ins_v[7:0], 8'hff);
      collect(8);
      check("byte again", got[7:0], b);
      // Superframe-twelve: six bits out, byte in at boundary
      esf_mode <= 1'b0;
      wr(ADR_TX_DL_BYTE, 8'hdc);
      repeat (2) begin
         wr(ADR_TX_LSTAT2, 8'h10);
         wait_flag(BIT_TX_EMPTY);
      end
      collect(6);
      check("d4 bits", {2'b00, got[5:0]}, 8'h1c);
      tdl_line_model_inst.send_bits({8'h00, b}, 8);
      rd(ADR_RX_DL_BYTE, w[15:8], 8'hff);
      tdl_line_model_inst.rx_mf_stb <= 1'b1;
      @(posedge clk_sys);
      tdl_line_model_inst.rx_mf_stb <= 1'b0;
      rd(ADR_RX_DL_BYTE, b, 8'hff);
      // Pass-through, then E1 mode, stop all insertion
      wr(ADR_TX_CTRL1, 8'h40);
      collect(4);
      check("pass ins", ins_v[7:0], 8'h00);
      wr(ADR_TX_CTRL1, 8'h00);
      t1_mode <= 1'b0;
      collect(4);
      check("e1 ins", ins_v[7:0], 8'h00);
      stop_test();
   end
endmodule
bind tdl_boc_fdl tdl_boc_fdl_props #(.ABORT_BITS(ABORT_BITS)) tdl_boc_fdl_props_inst (
   .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rd_data(rd_data), .t1_mode(t1_mode), .esf_mode(esf_mode),
   .tx_bit_req(tx_bit_req), .tx_serial_in(tx_serial_in), .tx_dl_bit(tx_dl_bit),
   .tx_dl_insert(tx_dl_insert), .rx_bit_stb(rx_bit_stb), .rx_bit(rx_bit),
   .rx_mf_stb(rx_mf_stb), .interrupt_out_n(interrupt_out_n));
`default_nettype wire
